//--- shared/iswu_cfg.svh
// constants of the interrupt and stop wake unit
`ifndef ISWU_CFG_SVH
`define ISWU_CFG_SVH

`define ISWU_ADDR_W      3
`define ISWU_DATA_W      8
`define ISWU_VEC_W       12
`define ISWU_NSRC        8

// register indices on the plain register port
`define ISWU_REG_IRQ_EN  3'h0
`define ISWU_REG_FLAGS   3'h1
`define ISWU_REG_CTRL    3'h2
`define ISWU_REG_STATUS  3'h3

// control register fields
`define ISWU_CTRL_PSE_LSB  0
`define ISWU_CTRL_PSE_MSB  2
`define ISWU_CTRL_PLVL     3
`define ISWU_CTRL_KSE      4
`define ISWU_CTRL_KLVL     5

// flag indices per source
`define ISWU_SRC_PORT    0
`define ISWU_SRC_TIMER_ONE    1
`define ISWU_SRC_PIN     2
`define ISWU_SRC_PRE     3
`define ISWU_SRC_TIMER_TWO    4
`define ISWU_SRC_KEY     5
`define ISWU_SRC_RFC     6
`define ISWU_SRC_TIMER_THREE    7

// external sources that wake from stop
`define ISWU_EXT_MASK    8'h25

// vector table, source 7 in the top slice
`define ISWU_VEC_TABLE   {12'h02c, 12'h028, 12'h024, 12'h020, 12'h01c, 12'h010, 12'h018, 12'h014}

// sources from highest to lowest priority, first in the low slice
`define ISWU_PRIO_ORDER  {3'h5, 3'h2, 3'h0, 3'h6, 3'h7, 3'h4, 3'h1, 3'h3}

`define ISWU_RST_BYTE    8'h00
`define ISWU_RST_VEC     12'h000

`endif

//--- shared/iswu_pkg.sv
// types of the interrupt and stop wake unit
package iswu_pkg;

  // class of the instruction the core starts
  typedef enum logic [2:0] {
    OP_PLAIN      = 3'h0,
    OP_EIGHT_CYC  = 3'h1,
    OP_SHIFT_BANK = 3'h2,
    OP_ACC_EIGHT  = 3'h3,
    OP_TABLE_COPY = 3'h4,
    OP_SET_IRQ_EN = 3'h5,
    OP_RETURN     = 3'h6
  } iswu_op_e;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_STOP = 2'b10
  } iswu_state_e;

endpackage : iswu_pkg

//--- src/iswu_prio.sv
// fixed priority selector over the eight request lines
`timescale 1ns/1ps
`include "iswu_cfg.svh"

module iswu_prio (
  input  wire logic [`ISWU_NSRC-1:0] req,
  output logic                       any,
  output logic [2:0]                 idx
);

  localparam logic [23:0] ORDER = `ISWU_PRIO_ORDER;

  // walk from lowest rank up so the highest ranked request wins last
  always_comb begin
    any = 1'b0;
    idx = 3'h0;
    for (int r = `ISWU_NSRC - 1; r >= 0; r--) begin
      if (req[ORDER[r*3 +: 3]]) begin
        any = 1'b1;
        idx = ORDER[r*3 +: 3];
      end
    end
  end

endmodule : iswu_prio

//--- src/iswu_top.sv
// interrupt request, priority and stop wake unit
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "iswu_cfg.svh"

module iswu_top #(
  parameter bit INT_RISING = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // register port
  input  wire logic [`ISWU_ADDR_W-1:0] reg_addr,
  input  wire logic [`ISWU_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`ISWU_DATA_W-1:0] reg_rdata_q,
  // request sources
  input  wire logic                    int_pin,
  input  wire logic [3:0]              port_group_a,
  input  wire logic [3:0]              port_group_c,
  input  wire logic [3:0]              port_group_d,
  input  wire logic [3:0]              keyscan_inputs,
  input  wire logic                    scan_cycle_end,
  input  wire logic                    timer_one_uf,
  input  wire logic                    timer_two_uf,
  input  wire logic                    timer_three_uf,
  input  wire logic                    prescaler_ovf,
  input  wire logic                    rfc_period_end,
  // core sequencer
  input  wire logic                    op_start,
  input  wire iswu_pkg::iswu_op_e      op_class,
  input  wire logic                    stop_req,
  output logic                         irq_take_q,
  output logic      [`ISWU_VEC_W-1:0]  irq_vector_q,
  output logic                         stop_active,
  output logic                         stop_refused_q,
  output logic                         wake_plain_q
);

  localparam logic [`ISWU_NSRC*`ISWU_VEC_W-1:0] VECS = `ISWU_VEC_TABLE;
  localparam logic [`ISWU_NSRC-1:0] EXT = `ISWU_EXT_MASK;

  logic [`ISWU_NSRC-1:0]  flag_q, flag_d, en_q, en_d, set_v, clr_v;
  logic [2:0]             pse_q;
  logic                   plvl_q, kse_q, klvl_q;
  logic                   pin_q;
  logic [11:0]            port_q;
  logic [3:0]             key_q;
  logic                   after_q, ret_stop_q;
  iswu_pkg::iswu_state_e  state_q, state_d;

  wire in_stop = (state_q == iswu_pkg::ST_STOP);
  wire in_run  = (state_q == iswu_pkg::ST_RUN);
  assign stop_active = in_stop;

  // register decode
  wire wr_en    = reg_wr && (reg_addr == `ISWU_REG_IRQ_EN);
  wire wr_flags = reg_wr && (reg_addr == `ISWU_REG_FLAGS);
  wire wr_ctrl  = reg_wr && (reg_addr == `ISWU_REG_CTRL);

  // pin edge, sampled once per machine cycle; shorter pulses may be missed
  wire pin_rise = int_pin && !pin_q;
  wire pin_fall = !int_pin && pin_q;
  wire pin_edge = INT_RISING ? pin_rise : pin_fall;

  // port groups masked by their switch enables
  wire [11:0] port_now = {port_group_d & {4{pse_q[2]}},
                          port_group_c & {4{pse_q[1]}},
                          port_group_a & {4{pse_q[0]}}};
  wire [11:0] port_old = port_q & {{4{pse_q[2]}}, {4{pse_q[1]}}, {4{pse_q[0]}}};
  wire port_any_high = |(port_now & ~port_old);
  wire port_or_chg   = (|port_now) != (|port_old);
  wire port_evt = plvl_q ? port_any_high : port_or_chg;

  // keyscan: end of scan cycle, or a key going high in level mode
  wire key_high = |(keyscan_inputs & ~key_q);
  wire key_evt  = kse_q && (klvl_q ? key_high : scan_cycle_end);

  // internal sources are frozen while stopped
  wire run_ok = in_run;

  // event vector in flag order
  assign set_v[`ISWU_SRC_PORT] = port_evt;
  assign set_v[`ISWU_SRC_TIMER_ONE] = timer_one_uf && run_ok;
  assign set_v[`ISWU_SRC_PIN]  = pin_edge && en_q[`ISWU_SRC_PIN];
  assign set_v[`ISWU_SRC_PRE]  = prescaler_ovf && run_ok;
  assign set_v[`ISWU_SRC_TIMER_TWO] = timer_two_uf && run_ok;
  assign set_v[`ISWU_SRC_KEY]  = key_evt;
  assign set_v[`ISWU_SRC_RFC]  = rfc_period_end && run_ok;
  assign set_v[`ISWU_SRC_TIMER_THREE] = timer_three_uf && run_ok;

  // hold-off: classes that block acceptance, plus the instruction after some
  wire cls_hold = (op_class == iswu_pkg::OP_EIGHT_CYC)  ||
                  (op_class == iswu_pkg::OP_SHIFT_BANK) ||
                  (op_class == iswu_pkg::OP_ACC_EIGHT)  ||
                  (op_class == iswu_pkg::OP_TABLE_COPY) ||
                  (op_class == iswu_pkg::OP_SET_IRQ_EN) ||
                  (op_class == iswu_pkg::OP_RETURN);
  wire hold = cls_hold || after_q;
  wire sets_after = (op_class == iswu_pkg::OP_SHIFT_BANK) ||
                    (op_class == iswu_pkg::OP_TABLE_COPY);

  // pending requests; only external ones can fire while stopped
  wire [`ISWU_NSRC-1:0] pend = flag_q & en_q & (in_stop ? EXT : {`ISWU_NSRC{1'b1}});
  logic       sel_any;
  logic [2:0] sel_idx;

  iswu_prio u_prio (
    .req (pend),
    .any (sel_any),
    .idx (sel_idx)
  );

  // acceptance at an instruction start, or at once while stopped
  wire accept = sel_any && (in_stop || (op_start && !hold));
  wire [`ISWU_VEC_W-1:0] vec_sel = VECS[sel_idx*`ISWU_VEC_W +: `ISWU_VEC_W];

  // a non-interrupt wake: external flag without a taken request
  wire ext_pend  = |(flag_q & EXT);
  wire wake_evt  = in_stop && ext_pend && !accept;
  wire ret_back  = in_run && op_start && (op_class == iswu_pkg::OP_RETURN) && ret_stop_q;
  wire stop_ok   = in_run && stop_req && !ext_pend;
  wire stop_no   = in_run && stop_req && ext_pend;

  // clear vector: software write-one, the taken source, or all when a request is taken while stopped
  always_comb begin
    clr_v = wr_flags ? reg_wdata : `ISWU_RST_BYTE;
    if (accept && in_stop) begin
      clr_v = {`ISWU_NSRC{1'b1}};
    end else if (accept) begin
      clr_v[sel_idx] = 1'b1;
    end
  end

  // per flag update, set wins over clear
  for (genvar i = 0; i < `ISWU_NSRC; i++) begin : g_flag
    assign flag_d[i] = set_v[i] || (flag_q[i] && !clr_v[i]);
  end

  // enables: software loads them, acceptance clears them all
  assign en_d = accept ? `ISWU_RST_BYTE : (wr_en ? reg_wdata : en_q);

  // run/stop sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iswu_pkg::ST_RUN: begin
        if (stop_ok || ret_back) begin
          state_d = iswu_pkg::ST_STOP;
        end
      end
      iswu_pkg::ST_STOP: begin
        if (accept || wake_evt) begin
          state_d = iswu_pkg::ST_RUN;
        end
      end
      default: state_d = iswu_pkg::ST_RUN;
    endcase
  end

  // read mux
  wire [`ISWU_DATA_W-1:0] ctrl_rd = {2'h0, klvl_q, kse_q, plvl_q, pse_q};
  wire [`ISWU_DATA_W-1:0] stat_rd = {5'h00, ret_stop_q, in_run, in_stop};
  wire [`ISWU_DATA_W-1:0] rd_mux =
    (reg_addr == `ISWU_REG_IRQ_EN) ? en_q :
    (reg_addr == `ISWU_REG_FLAGS)  ? flag_q :
    (reg_addr == `ISWU_REG_CTRL)   ? ctrl_rd :
    (reg_addr == `ISWU_REG_STATUS) ? stat_rd : `ISWU_RST_BYTE;

  // flags, enables and control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_q <= `ISWU_RST_BYTE;
      en_q   <= `ISWU_RST_BYTE;
      pse_q  <= 3'h0;
      plvl_q <= 1'b0;
      kse_q  <= 1'b0;
      klvl_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      en_q   <= en_d;
      if (wr_ctrl) begin
        pse_q  <= reg_wdata[`ISWU_CTRL_PSE_MSB:`ISWU_CTRL_PSE_LSB];
        plvl_q <= reg_wdata[`ISWU_CTRL_PLVL];
        kse_q  <= reg_wdata[`ISWU_CTRL_KSE];
        klvl_q <= reg_wdata[`ISWU_CTRL_KLVL];
      end
    end
  end

  // input history for edge detection; cleared to low so a high at release counts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_q  <= 1'b0;
      port_q <= 12'h000;
      key_q  <= 4'h0;
    end else begin
      pin_q  <= int_pin;
      port_q <= {port_group_d, port_group_c, port_group_a};
      key_q  <= keyscan_inputs;
    end
  end

  // sequencing state and the follow-on hold
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q    <= iswu_pkg::ST_RUN;
      after_q    <= 1'b0;
      ret_stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (op_start) begin
        after_q <= sets_after;
      end
      if (accept && in_stop) begin
        ret_stop_q <= 1'b1;
      end else if (ret_back) begin
        ret_stop_q <= 1'b0;
      end
    end
  end

  // outputs to the core and the register port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_take_q     <= 1'b0;
      irq_vector_q   <= `ISWU_RST_VEC;
      stop_refused_q <= 1'b0;
      wake_plain_q   <= 1'b0;
      reg_rdata_q    <= `ISWU_RST_BYTE;
    end else begin
      irq_take_q     <= accept;
      stop_refused_q <= stop_no;
      wake_plain_q   <= wake_evt;
      reg_rdata_q    <= reg_rd ? rd_mux : `ISWU_RST_BYTE;
      if (accept) begin
        irq_vector_q <= vec_sel;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_take_vec;
    accept |=> irq_take_q && (irq_vector_q == $past(vec_sel));
  endproperty
  a_take_vec: assert property (p_take_vec) else $error("vector not delivered");

  property p_en_clear;
    accept |=> (en_q == 8'h00) ##1 !irq_take_q;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enables not cleared");

  property p_flag_clear;
    accept && in_run && !set_v[sel_idx] |=> !flag_q[$past(sel_idx)];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("taken flag kept");

  property p_hold;
    op_start && in_run && (cls_hold || after_q) |-> !accept;
  endproperty
  a_hold: assert property (p_hold) else $error("accepted in hold-off");

  // class of the previous instruction, kept apart from the hold logic so the check is independent
  iswu_pkg::iswu_op_e prev_cls_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_cls_q <= iswu_pkg::OP_PLAIN;
    end else if (op_start) begin
      prev_cls_q <= op_class;
    end
  end

  property p_after;
    op_start && in_run &&
      ((prev_cls_q == iswu_pkg::OP_SHIFT_BANK) || (prev_cls_q == iswu_pkg::OP_TABLE_COPY)) |-> !accept;
  endproperty
  a_after: assert property (p_after) else $error("accepted after shift or copy");

  property p_stop_refuse;
    stop_req && in_run && ext_pend |=> in_run && stop_refused_q;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("stop entered with flags");

  property p_stop_wake;
    in_stop && accept |=> in_run && ((flag_q & ~$past(set_v)) == 8'h00) && irq_take_q;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake not clean");

  property p_rts_back;
    ret_back |=> in_stop && !ret_stop_q;
  endproperty
  a_rts_back: assert property (p_rts_back) else $error("no return to stop");

  property p_prio_pre;
    accept && pend[`ISWU_SRC_PRE] |-> ##1 (irq_vector_q == 12'h01c);
  endproperty
  a_prio_pre: assert property (p_prio_pre) else $error("prescaler not first");

  property p_timer_set;
    timer_one_uf && in_run |=> flag_q[`ISWU_SRC_TIMER_ONE];
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag missed");

  property p_pin_set;
    pin_edge && en_q[`ISWU_SRC_PIN] |=> flag_q[`ISWU_SRC_PIN];
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin flag missed");

  property p_port_set;
    port_evt |=> flag_q[`ISWU_SRC_PORT];
  endproperty
  a_port_set: assert property (p_port_set) else $error("port flag missed");

  property p_key_set;
    key_evt |=> flag_q[`ISWU_SRC_KEY];
  endproperty
  a_key_set: assert property (p_key_set) else $error("keyscan flag missed");

  property p_rfc_set;
    rfc_period_end && in_run |=> flag_q[`ISWU_SRC_RFC];
  endproperty
  a_rfc_set: assert property (p_rfc_set) else $error("counter flag missed");

  property p_stop_enter;
    stop_req && in_run && !ext_pend |=> in_stop;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

endmodule : iswu_top

//--- verif/iswu_core_model.sv
// core sequencer and pin source model facing the interrupt unit
`timescale 1ns/1ps

module iswu_core_model (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               issue,
  input  wire iswu_pkg::iswu_op_e cls,
  input  wire logic               pin_flip,
  input  wire logic               irq_take_q,
  input  wire logic               wake_plain_q,
  output logic                    op_start,
  output iswu_pkg::iswu_op_e      op_class,
  output logic                    int_pin,
  output int                      takes,
  output int                      wakes
);
  // one instruction start per issue; counters stand in for stack push and wake handling
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_start <= 1'b0;
      op_class <= iswu_pkg::OP_PLAIN;
      int_pin  <= 1'b0;
      takes    <= 0;
      wakes    <= 0;
    end else begin
      op_start <= issue;
      op_class <= cls;
      // each new pin level stands until the next flip, far longer than one cycle
      if (pin_flip) begin
        int_pin <= !int_pin;
      end
      if (irq_take_q) begin
        takes <= takes + 1;
      end
      if (wake_plain_q) begin
        wakes <= wakes + 1;
      end
    end
  end
endmodule : iswu_core_model

//--- verif/iswu_top_test.sv
// self-checking bench for the interrupt and stop wake unit
`timescale 1ns/1ps

module iswu_top_test;
  localparam logic [95:0] VEXP = {12'h024, 12'h010, 12'h014, 12'h028, 12'h02c, 12'h020, 12'h018, 12'h01c};
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic [2:0]         reg_addr = 3'h0;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata_q;
  logic [3:0]         port_group_a = 4'h0;
  logic [3:0]         port_group_c = 4'h0;
  logic [3:0]         port_group_d = 4'h0;
  logic               scan_end = 1'b0;
  logic [7:0]         fall_rdata_q;
  logic [3:0]         keyscan_inputs = 4'h0;
  logic [4:0]         tick = 5'h00;
  logic               issue = 1'b0;
  logic               pin_flip = 1'b0;
  logic               stop_req = 1'b0;
  iswu_pkg::iswu_op_e cls = iswu_pkg::OP_PLAIN;
  iswu_pkg::iswu_op_e op_class;
  logic               op_start;
  logic               int_pin;
  logic               irq_take_q;
  logic [11:0]        irq_vector_q;
  logic               stop_active;
  logic               stop_refused_q;
  logic               wake_plain_q;
  int                 takes;
  int                 wakes;
  int                 num_errors = 0;
  int                 checks = 0;

  always #2 clk = !clk;

  iswu_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .int_pin(int_pin), .port_group_a(port_group_a),
    .port_group_c(port_group_c), .port_group_d(port_group_d), .keyscan_inputs(keyscan_inputs),
    .scan_cycle_end(scan_end),
    .timer_one_uf(tick[0]), .timer_two_uf(tick[1]), .timer_three_uf(tick[2]), .prescaler_ovf(tick[3]),
    .rfc_period_end(tick[4]), .op_start(op_start), .op_class(op_class), .stop_req(stop_req),
    .irq_take_q(irq_take_q), .irq_vector_q(irq_vector_q), .stop_active(stop_active),
    .stop_refused_q(stop_refused_q), .wake_plain_q(wake_plain_q));

  // falling-edge build on the same stimulus; only its flags register is compared
  iswu_top #(.INT_RISING(1'b0)) uut_fall (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(fall_rdata_q), .int_pin(int_pin),
    .port_group_a(port_group_a), .port_group_c(port_group_c), .port_group_d(port_group_d),
    .keyscan_inputs(keyscan_inputs), .scan_cycle_end(scan_end), .timer_one_uf(tick[0]),
    .timer_two_uf(tick[1]), .timer_three_uf(tick[2]), .prescaler_ovf(tick[3]), .rfc_period_end(tick[4]),
    .op_start(op_start), .op_class(op_class), .stop_req(stop_req), .irq_take_q(), .irq_vector_q(),
    .stop_active(), .stop_refused_q(), .wake_plain_q());

  iswu_core_model core (.clk(clk), .reset_n(reset_n), .issue(issue), .cls(cls), .pin_flip(pin_flip),
    .irq_take_q(irq_take_q), .wake_plain_q(wake_plain_q), .op_start(op_start), .op_class(op_class),
    .int_pin(int_pin), .takes(takes), .wakes(wakes));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // one-cycle strobes driven just after the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("read data", reg_rdata_q, exp);
  endtask : rd

  // take latency is fixed: one cycle after the instruction start
  task automatic op(input iswu_pkg::iswu_op_e c, input int n);
    int t0;
    t0 = takes;
    @(posedge clk);
    issue <= 1'b1;
    cls   <= c;
    @(posedge clk);
    issue <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("accepted count", 12'(takes - t0), 12'(n));
  endtask : op

  task automatic stp(input logic act, input logic refused);
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    #1;
    check("stop active", stop_active, act);
    check("stop refused", stop_refused_q, refused);
  endtask : stp

  task automatic flip();
    @(posedge clk);
    pin_flip <= 1'b1;
    @(posedge clk);
    pin_flip <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : flip

  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    tick <= m;
    @(posedge clk);
    tick <= 5'h00;
  endtask : pulse

  // hang guard: running out counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h02);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    $display("test reset done");
    // every source pending at once, then served one by one
    wr(3'h0, 8'hff);
    wr(3'h2, 8'h39);
    @(posedge clk);
    port_group_a   <= 4'h1;
    keyscan_inputs <= 4'h2;
    pulse(5'h1f);
    port_group_a   <= 4'h0;
    keyscan_inputs <= 4'h0;
    flip();
    rd(3'h1, 8'hff);
    for (int i = 0; i < 8; i++) begin
      op(iswu_pkg::OP_PLAIN, 1);
      check("vector", irq_vector_q, VEXP[i*12 +: 12]);
      rd(3'h0, 8'h00);
      wr(3'h0, 8'hff);
    end
    rd(3'h1, 8'h00);
    $display("test priority done");
    // held instruction classes keep a request pending
    wr(3'h0, 8'h02);
    pulse(5'h01);
    op(iswu_pkg::OP_EIGHT_CYC, 0);
    op(iswu_pkg::OP_ACC_EIGHT, 0);
    op(iswu_pkg::OP_SET_IRQ_EN, 0);
    op(iswu_pkg::OP_RETURN, 0);
    op(iswu_pkg::OP_SHIFT_BANK, 0);
    op(iswu_pkg::OP_PLAIN, 0);
    op(iswu_pkg::OP_TABLE_COPY, 0);
    op(iswu_pkg::OP_PLAIN, 0);
    op(iswu_pkg::OP_PLAIN, 1);
    $display("test hold done");
    // stop refused, entered, left by pin interrupt, re-entered on return
    wr(3'h0, 8'h04);
    wr(3'h2, 8'h00);
    // the pin falls first: only the falling-edge build flags it
    flip();
    rd(3'h1, 8'h00);
    check("falling pin flags", fall_rdata_q, 12'h004);
    flip();
    rd(3'h1, 8'h04);
    stp(1'b0, 1'b1);
    wr(3'h1, 8'hff);
    pulse(5'h02);
    stp(1'b1, 1'b0);
    pulse(5'h01);
    flip();
    flip();
    check("stop after pin", stop_active, 1'b0);
    check("vector", irq_vector_q, 12'h010);
    rd(3'h1, 8'h00);
    op(iswu_pkg::OP_RETURN, 0);
    check("stop after return", stop_active, 1'b1);
    $display("test stop done");
    // wake without interrupt keeps the port flag for software
    wr(3'h2, 8'h09);
    @(posedge clk);
    port_group_a <= 4'h4;
    repeat (6) @(posedge clk);
    port_group_a <= 4'h0;
    #1;
    check("plain wakes", 12'(wakes), 12'h001);
    check("stop after wake", stop_active, 1'b0);
    rd(3'h1, 8'h01);
    stp(1'b0, 1'b1);
    wr(3'h1, 8'hff);
    stp(1'b1, 1'b0);
    $display("test plain wake done");
    // debounce mode on groups c and d: any change of the ORed inputs, rising or falling, counts
    wr(3'h2, 8'h06);
    @(posedge clk);
    port_group_c <= 4'h8;
    repeat (4) @(posedge clk);
    #1;
    check("plain wakes", 12'(wakes), 12'h002);
    rd(3'h1, 8'h01);
    wr(3'h1, 8'hff);
    port_group_c <= 4'h0;
    repeat (3) @(posedge clk);
    rd(3'h1, 8'h01);
    wr(3'h1, 8'hff);
    port_group_d <= 4'h2;
    repeat (3) @(posedge clk);
    rd(3'h1, 8'h01);
    wr(3'h1, 8'hff);
    // keyscan in scan-end mode, then served at its vector
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h20);
    @(posedge clk);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    rd(3'h1, 8'h20);
    op(iswu_pkg::OP_PLAIN, 1);
    check("vector", irq_vector_q, 12'h024);
    $display("test debounce and scan done");
    complete_run();
  end
endmodule : iswu_top_test
